// file: fcid_pkg.sv
package fcid_pkg;
  localparam int unsigned SERIAL_WIDTH   = 64;
  localparam int unsigned CLK_FREQ_MHZ   = 10;
  localparam int unsigned MAX_FREQ_MHZ   = 100;
  localparam int unsigned FUSE_BIT_CNT   = 64;
  localparam logic [6:0]  FUSE_BIT_LAST  = 7'h3F;
  localparam logic [63:0] SERIAL_RESET   = 64'h0000_0000_0000_0000;
  // arbitrary neutral fuse content for the model of the fuse array
  localparam logic [63:0] FUSE_DEFAULT   = 64'h5A3C_96E1_0F1E_2D4B;
  typedef enum logic [1:0] {
    FCID_IDLE = 2'b00,
    FCID_LOAD = 2'b01,
    FCID_DONE = 2'b11
  } fcid_state_t;
endpackage : fcid_pkg

// file: fcid_fuse_shifter.sv
`timescale 1ns/1ns
`default_nettype none
// fuse array model: presents one fuse bit per cycle, lsb first
module fcid_fuse_shifter #(
  parameter logic [63:0] FUSE_VALUE = fcid_pkg::FUSE_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic [6:0] bitIndex,
  output logic            fuseBit
);
  logic fuseBitReg;
  wire  selBit = FUSE_VALUE[bitIndex[5:0]];

  always_ff @(posedge sys_clk) begin
    fuseBitReg <= selBit;
  end

  assign fuseBit = fuseBitReg;
endmodule : fcid_fuse_shifter
`default_nettype wire

// file: fcid_reader.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - With the clock running, the block fetches the serial value from the fuses onto a 64-bit output.
// - Holding nrst low for at least one clock returns the block to its initial state.
// - Once loaded, the serial value stays steady until reconfiguration or reset.
// - The ready flag stays low in the initial state and during loading.
// - The ready flag rises only once the serial value is valid.
// - From power-up the serial value reads zero until loaded.
module fcid_reader #(
  parameter logic [63:0] FUSE_VALUE = fcid_pkg::FUSE_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  output logic             dataValid,
  output logic [63:0]      device_serial_value
);
  fcid_pkg::fcid_state_t stateReg;
  fcid_pkg::fcid_state_t stateNext;
  logic [6:0]  bitIdxReg;
  logic [6:0]  bitIdxNext;
  logic [6:0]  capIdxReg;
  logic        capEnReg;
  logic [63:0] shiftReg;
  logic [63:0] serialReg;
  logic [63:0] serialNext;
  logic        validReg;
  logic        fuseBit;
  logic        lastIssuedReg;
  logic [6:0]  loadCntReg;

  // cycles spent in the load state when the last fuse bit is captured
  localparam logic [6:0] LOAD_CYCLES = 7'h40;

  // state decode shared by the issue logic and the checks
  function automatic logic fcid_is_loading(input fcid_pkg::fcid_state_t st);
    return st == fcid_pkg::FCID_LOAD;
  endfunction : fcid_is_loading

  // fuse bit arrives one cycle after its index is presented
  fcid_fuse_shifter #(
    .FUSE_VALUE (FUSE_VALUE)
  ) uFuse (
    .sys_clk  (sys_clk),
    .bitIndex (bitIdxReg),
    .fuseBit  (fuseBit)
  );

  wire lastIssue = fcid_is_loading(stateReg) && (bitIdxReg == fcid_pkg::FUSE_BIT_LAST);
  wire lastCap   = capEnReg && (capIdxReg == fcid_pkg::FUSE_BIT_LAST);
  // index stops once the last bit is issued, so no bit is captured twice
  wire issuing   = fcid_is_loading(stateReg) && !lastIssuedReg;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      fcid_pkg::FCID_IDLE: stateNext = fcid_pkg::FCID_LOAD;
      fcid_pkg::FCID_LOAD: begin
        if (lastCap) begin
          stateNext = fcid_pkg::FCID_DONE;
        end
      end
      fcid_pkg::FCID_DONE: stateNext = fcid_pkg::FCID_DONE;
      default:             stateNext = fcid_pkg::FCID_IDLE;
    endcase
  end

  assign bitIdxNext = issuing ? bitIdxReg + 7'h01 : bitIdxReg;
  // value moves to the output only as a whole, so no partial id is ever shown
  assign serialNext = lastCap ? {fuseBit, shiftReg[63:1]} : serialReg;

  // synchronous reset returns everything to the initial state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stateReg      <= fcid_pkg::FCID_IDLE;
      bitIdxReg     <= 7'h00;
      lastIssuedReg <= 1'b0;
      capEnReg      <= 1'b0;
      capIdxReg     <= 7'h00;
      shiftReg      <= fcid_pkg::SERIAL_RESET;
      serialReg     <= fcid_pkg::SERIAL_RESET;
      validReg      <= 1'b0;
    end else begin
      stateReg      <= stateNext;
      bitIdxReg     <= bitIdxNext;
      lastIssuedReg <= lastIssuedReg | lastIssue;
      capEnReg      <= issuing;
      capIdxReg     <= bitIdxReg;
      shiftReg      <= capEnReg ? {fuseBit, shiftReg[63:1]} : shiftReg;
      serialReg     <= serialNext;
      validReg      <= lastCap | validReg;
    end
  end

  assign dataValid           = validReg;
  assign device_serial_value = serialReg;

  // check helper: counts cycles spent loading since the last reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      loadCntReg <= 7'h00;
    end else if (fcid_is_loading(stateReg)) begin
      loadCntReg <= loadCntReg + 7'h01;
    end
  end

  // checks
  sequence loadDone_s;
    lastCap ##1 validReg;
  endsequence

  property validWithValue_p;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(validReg) |-> $changed(serialReg) || (serialReg == FUSE_VALUE);
  endproperty

  valid_needs_value_a: assert property (validWithValue_p)
    else $error("ready rose without the serial value");
  serial_stable_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      validReg |=> $stable(serialReg))
    else $error("serial value changed after load");
  serial_correct_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      validReg |-> serialReg == FUSE_VALUE)
    else $error("serial value differs from fuses");
  zero_before_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !validReg |-> serialReg == fcid_pkg::SERIAL_RESET)
    else $error("serial value nonzero before load");
  ready_low_loading_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      stateReg != fcid_pkg::FCID_DONE |-> !validReg)
    else $error("ready high while loading");
  reset_clears_a: assert property (@(posedge sys_clk)
      !nrst |=> !validReg && serialReg == fcid_pkg::SERIAL_RESET)
    else $error("reset did not clear the block");
  reload_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(nrst) |-> ##[66:70] validReg)
    else $error("fuse reload did not finish in time");
  done_sequence_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      lastCap |-> loadDone_s)
    else $error("ready missed after last fuse bit");

  // each issued index is followed by a capture one cycle later
  sequence issueStep_s;
    issuing ##1 capEnReg;
  endsequence

  sequence loadEntry_s;
    stateReg == fcid_pkg::FCID_IDLE ##1 stateReg == fcid_pkg::FCID_LOAD;
  endsequence

  issue_then_capture_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      issuing |-> issueStep_s)
    else $error("issued fuse bit was not captured");

  load_starts_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(nrst) |-> loadEntry_s)
    else $error("load did not start after reset release");

  fuse_bit_align_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      capEnReg |-> fuseBit == FUSE_VALUE[capIdxReg[5:0]])
    else $error("captured fuse bit out of step with its index");

  capture_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      capEnReg |-> capIdxReg <= fcid_pkg::FUSE_BIT_LAST)
    else $error("capture index beyond the last fuse bit");

  issue_stops_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      lastIssuedReg |-> !issuing && bitIdxReg == 7'h40)
    else $error("fuse index moved after the last bit");

  load_length_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      lastCap |-> loadCntReg == LOAD_CYCLES)
    else $error("fuse load took the wrong number of cycles");

  done_holds_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      stateReg == fcid_pkg::FCID_DONE |=> stateReg == fcid_pkg::FCID_DONE)
    else $error("loaded state left without reset");

  valid_in_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      validReg |-> stateReg == fcid_pkg::FCID_DONE)
    else $error("ready high outside the loaded state");

  valid_holds_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      validReg |=> validReg)
    else $error("ready fell without reset");

  no_early_valid_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      fcid_is_loading(stateReg) && !lastCap |=> !validReg)
    else $error("ready rose before the last fuse bit");
endmodule : fcid_reader
`default_nettype wire

// file: fcid_user_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side user logic: takes the serial value only while the flag is high
module fcid_user_model (
  input  wire logic        sys_clk,
  input  wire logic        dataValid,
  input  wire logic [63:0] device_serial_value,
  output var  logic [63:0] takenValue
);
  initial takenValue = 64'h0;
  always @(posedge sys_clk) begin
    if (dataValid) takenValue <= device_serial_value;
  end
endmodule : fcid_user_model
`default_nettype wire

// file: fcid_testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h seen %h", nm, e, g); end end
module testbench;
  localparam logic [63:0] FUSE = 64'hC3A5_0123_89AB_7E10;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        dataValid;
  logic [63:0] serial;
  logic [63:0] taken;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  fcid_reader #(.FUSE_VALUE(FUSE)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .dataValid(dataValid),
    .device_serial_value(serial));
  fcid_user_model i_user (.sys_clk(sys_clk), .dataValid(dataValid), .device_serial_value(serial),
    .takenValue(taken));
  initial forever #50 sys_clk = ~sys_clk;
  // whole run needs well under 400 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // release reset, track zero value until flag, then check hold
  task automatic run_load;
    int k;
    k = 0;
    @(negedge sys_clk) nrst = 1'b1;
    while (dataValid !== 1'b1 && k < 80) begin
      `CHK("serial before flag", 64'h0, serial)
      @(negedge sys_clk);
      k++;
    end
    `CHK("flag latency ok", 1'b1, k >= 66 && k <= 70)
    `CHK("serial loaded", FUSE, serial)
    repeat (20) begin
      @(negedge sys_clk);
      `CHK("serial held", FUSE, serial)
      `CHK("flag held", 1'b1, dataValid)
    end
    `CHK("user taken", FUSE, taken)
  endtask : run_load
  // one-cycle reset after load, then again mid-load
  task automatic reset_checks;
    @(negedge sys_clk) nrst = 1'b0;
    @(negedge sys_clk);
    `CHK("flag cleared", 1'b0, dataValid)
    `CHK("serial cleared", 64'h0, serial)
    nrst = 1'b1;
    repeat (30) @(negedge sys_clk);
    `CHK("flag low in load", 1'b0, dataValid)
    nrst = 1'b0;
    run_load();
  endtask : reset_checks
  initial begin
    repeat (10) @(negedge sys_clk);
    `CHK("serial at power-up", 64'h0, serial)
    `CHK("flag at power-up", 1'b0, dataValid)
    run_load();
    reset_checks();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
